/* rph_top.sv */
// Purpose: packet framer and deframer between FIFOs and a byte-wide modem
// Assumes: modem moves one byte per strobe; host obeys the idle-only rules
// Notes:   address filtering and FIFO flush on crc failure are not built
// Notes on behaviour
// - tx adds preamble bytes and sync word
// - preamble and sync always go together
// - optional crc trailer over data field
// - rx detects preamble, sync, checks crc, length
// - first status byte is signal strength
// - second status bit7 is crc ok
// - order preamble sync length address payload crc
// - preamble is 10101010, count minimum
// - keep preamble while tx fifo empty
// - sync mode 3 or 7 doubles sync
// - fixed, variable lengths up to 255
// - mode 0 uses nonzero length register
// - mode 1 first byte is payload length
// - drop packets longer than maximum length
// - mode 2 runs until host stops
// - payload has at least one byte
// - packet ends when counter equals register
// - long packets switch infinite to fixed
// - byte counter wraps 255 to 0
// - sync word sent msb first
// - underflow holds until flush command
`timescale 1ns/1ps
module rph_top (
	input  wire logic             I_CLK,
	input  wire logic             I_RST_B,
	input  wire rph_pkg::rph_cfg_s I_CFG,
	input  wire logic             I_TX_EN,
	input  wire logic             I_RX_EN,
	input  wire logic             I_TX_FIFO_FLUSH_CMD,
	input  wire logic             I_TX_FIFO_VALID,
	input  wire logic [7:0]       I_TX_FIFO_DATA,
	output logic                  O_TX_FIFO_READY,
	input  wire logic             I_MOD_READY,
	output logic                  O_MOD_VALID,
	output logic [7:0]            O_MOD_DATA,
	input  wire logic             I_DEM_VALID,
	input  wire logic [7:0]       I_DEM_DATA,
	input  wire logic [7:0]       I_SIGNAL_STRENGTH_VALUE,
	output logic                  O_RX_FIFO_VALID,
	output logic [7:0]            O_RX_FIFO_DATA,
	output logic                  O_TX_UNDERFLOW_STATE,
	output logic                  O_TX_DONE,
	output logic                  O_RX_DONE,
	output logic                  O_RX_DISCARD,
	output logic                  O_SYNC_SEEN
);
	import rph_pkg::*;

	// crc-16 over one byte, msb first
	function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c;
		for (int i = 7; i >= 0; i--) begin
			if (r[15] ^ d[i]) begin
				r = {r[14:0], 1'b0} ^ CRC_POLY;
			end else begin
				r = {r[14:0], 1'b0};
			end
		end
		return r;
	endfunction

	// ---------------- transmit side ----------------
	rph_state_e  tx_st_reg, tx_st_next;
	logic [7:0]  tx_cnt_reg;
	logic [7:0]  tx_len_reg;
	logic [1:0]  tx_sidx_reg;
	logic        tx_first_reg;
	logic [15:0] tx_crc_reg;
	logic        tx_crc_lo_reg;
	logic [7:0]  mod_data_reg;
	logic        mod_valid_reg;

	wire         sync_dbl   = (I_CFG.sync_mode == SYNC_DBL_A) || (I_CFG.sync_mode == SYNC_DBL_B);
	wire  [1:0]  sync_last  = sync_dbl ? 2'h3 : 2'h1;
	wire  [7:0]  sync_byte  = tx_sidx_reg[0] ? I_CFG.syncword_low_byte : I_CFG.syncword_high_byte;
	wire         mod_take   = ~mod_valid_reg | I_MOD_READY;
	wire         pre_done   = tx_cnt_reg >= I_CFG.num_preamble;
	wire         tx_in_data = tx_st_reg == ST_DATA;
	wire         tx_pull    = tx_in_data & mod_take & I_TX_FIFO_VALID;
	// end of data: counter meets limit, infinite mode never ends
	wire  [7:0]  tx_limit   = (I_CFG.length_mode == LEN_VARIABLE) ? tx_len_reg : I_CFG.packet_length_limit;
	wire         tx_len_cnt = (I_CFG.length_mode == LEN_VARIABLE) && tx_first_reg;
	wire         tx_last    = (I_CFG.length_mode != LEN_INFINITE) && !tx_len_cnt
	                          && (tx_cnt_reg + 8'h01 == tx_limit);

	// the fifo is popped only while data bytes flow to the modem
	assign O_TX_FIFO_READY      = tx_in_data & mod_take;
	assign O_MOD_VALID          = mod_valid_reg;
	assign O_MOD_DATA           = mod_data_reg;
	assign O_TX_UNDERFLOW_STATE = tx_st_reg == ST_UFLOW;
	assign O_TX_DONE            = tx_st_reg == ST_DONE;

	// transmit sequencer
	always_comb begin
		tx_st_next = tx_st_reg;
		case (tx_st_reg)
			ST_IDLE:  if (I_TX_EN) tx_st_next = ST_PRE;
			ST_PRE:   if (mod_take && pre_done && I_TX_FIFO_VALID) tx_st_next = ST_SYNC;
			ST_SYNC:  if (mod_take && tx_sidx_reg == sync_last) tx_st_next = ST_DATA;
			ST_DATA: begin
				if (mod_take && !I_TX_FIFO_VALID) tx_st_next = ST_UFLOW;
				else if (tx_pull && tx_last) tx_st_next = I_CFG.crc_en ? ST_CRC : ST_DONE;
			end
			ST_CRC:   if (mod_take && tx_crc_lo_reg) tx_st_next = ST_DONE;
			ST_DONE:  tx_st_next = ST_IDLE;
			ST_UFLOW: if (I_TX_FIFO_FLUSH_CMD) tx_st_next = ST_IDLE;
			default:  tx_st_next = ST_IDLE;
		endcase
		if (!I_TX_EN && tx_st_reg != ST_UFLOW) tx_st_next = ST_IDLE;
	end

	// transmit state register
	always_ff @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			tx_st_reg <= ST_IDLE;
		end else begin
			tx_st_reg <= tx_st_next;
		end
	end

	// transmit counters, crc and output byte
	always_ff @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			tx_cnt_reg    <= 8'h00;
			tx_len_reg    <= 8'h00;
			tx_sidx_reg   <= 2'h0;
			tx_first_reg  <= 1'b0;
			tx_crc_reg    <= CRC_INIT;
			tx_crc_lo_reg <= 1'b0;
			mod_data_reg  <= 8'h00;
			mod_valid_reg <= 1'b0;
		end else begin
			if (I_MOD_READY) mod_valid_reg <= 1'b0;
			if (tx_st_reg == ST_IDLE) begin
				tx_cnt_reg    <= 8'h00;
				tx_sidx_reg   <= 2'h0;
				tx_crc_reg    <= CRC_INIT;
				tx_crc_lo_reg <= 1'b0;
			end else if (mod_take) begin
				case (tx_st_reg)
					ST_PRE: begin
						// the exit step still emits preamble, which only lengthens it
						mod_data_reg  <= PREAMBLE_BYTE;
						mod_valid_reg <= 1'b1;
						if (!pre_done) tx_cnt_reg <= tx_cnt_reg + 8'h01;
					end
					ST_SYNC: begin
						mod_data_reg  <= sync_byte;
						mod_valid_reg <= 1'b1;
						tx_sidx_reg   <= tx_sidx_reg + 2'h1;
						tx_cnt_reg    <= 8'h00;
						tx_first_reg  <= 1'b1;
					end
					ST_DATA: if (I_TX_FIFO_VALID) begin
						mod_data_reg  <= I_TX_FIFO_DATA;
						mod_valid_reg <= 1'b1;
						tx_crc_reg    <= crc_byte(tx_crc_reg, I_TX_FIFO_DATA);
						tx_first_reg  <= 1'b0;
						if (tx_len_cnt) tx_len_reg <= I_TX_FIFO_DATA;
						else tx_cnt_reg <= tx_cnt_reg + 8'h01;
					end
					ST_CRC: begin
						mod_data_reg  <= tx_crc_lo_reg ? tx_crc_reg[7:0] : tx_crc_reg[15:8];
						mod_valid_reg <= 1'b1;
						tx_crc_lo_reg <= 1'b1;
					end
					default: ;
				endcase
			end
		end
	end

	// ---------------- receive side ----------------
	rph_state_e  rx_st_reg, rx_st_next;
	logic [31:0] rx_sh_reg;
	logic [7:0]  rx_cnt_reg;
	logic [7:0]  rx_len_reg;
	logic        rx_first_reg;
	logic [2:0]  rx_pre_reg;
	logic [15:0] rx_crc_reg;
	logic        rx_crc_lo_reg;
	logic        rx_stat2_reg;
	logic [7:0]  rx_data_reg;
	logic        rx_valid_reg;
	logic        rx_disc_reg;

	// receive decode: the preamble window spans four bytes so that a
	// doubled sync field, whose last byte lands four bytes after the
	// preamble, still qualifies
	wire  [15:0] sync16   = {I_CFG.syncword_high_byte, I_CFG.syncword_low_byte};
	wire  [31:0] shifted  = {rx_sh_reg[23:0], I_DEM_DATA};
	wire         pre_seen = rx_pre_reg != 3'h0;
	wire         sync_hit = sync_dbl ? (shifted == {sync16, sync16}) : (shifted[15:0] == sync16);
	wire         rx_len_b = (I_CFG.length_mode == LEN_VARIABLE) && rx_first_reg;
	wire         len_bad  = (I_DEM_DATA > I_CFG.packet_length_limit) || (I_DEM_DATA == 8'h00);
	wire  [7:0]  rx_limit = (I_CFG.length_mode == LEN_VARIABLE) ? rx_len_reg : I_CFG.packet_length_limit;
	wire         rx_last  = (I_CFG.length_mode != LEN_INFINITE) && !rx_len_b
	                        && (rx_cnt_reg + 8'h01 == rx_limit);
	wire         crc_good = !I_CFG.crc_en || (rx_crc_reg == 16'h0000);

	assign O_RX_FIFO_VALID = rx_valid_reg;
	assign O_RX_FIFO_DATA  = rx_data_reg;
	assign O_RX_DONE       = rx_st_reg == ST_DONE;
	assign O_RX_DISCARD    = rx_disc_reg;
	assign O_SYNC_SEEN     = rx_st_reg == ST_DATA && rx_first_reg;

	// receive sequencer
	always_comb begin
		rx_st_next = rx_st_reg;
		case (rx_st_reg)
			ST_IDLE: if (I_RX_EN) rx_st_next = ST_HUNT;
			ST_HUNT: if (I_DEM_VALID && pre_seen && sync_hit) rx_st_next = ST_DATA;
			ST_DATA: if (I_DEM_VALID) begin
				if (rx_len_b && len_bad) rx_st_next = ST_HUNT;
				else if (rx_last) rx_st_next = I_CFG.crc_en ? ST_CRC : ST_STAT;
			end
			ST_CRC:  if (I_DEM_VALID && rx_crc_lo_reg) rx_st_next = ST_STAT;
			ST_STAT: if (rx_stat2_reg || !I_CFG.append_status) rx_st_next = ST_DONE;
			ST_DONE: rx_st_next = ST_IDLE;
			default: rx_st_next = ST_IDLE;
		endcase
		if (!I_RX_EN) rx_st_next = ST_IDLE;
	end

	// receive state register
	always_ff @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			rx_st_reg <= ST_IDLE;
		end else begin
			rx_st_reg <= rx_st_next;
		end
	end

	// receive shifter, counters, crc and fifo write
	always_ff @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			rx_sh_reg     <= 32'h0000_0000;
			rx_cnt_reg    <= 8'h00;
			rx_len_reg    <= 8'h00;
			rx_first_reg  <= 1'b0;
			rx_pre_reg    <= 3'h0;
			rx_crc_reg    <= CRC_INIT;
			rx_crc_lo_reg <= 1'b0;
			rx_stat2_reg  <= 1'b0;
			rx_data_reg   <= 8'h00;
			rx_valid_reg  <= 1'b0;
			rx_disc_reg   <= 1'b0;
		end else begin
			rx_valid_reg <= 1'b0;
			rx_disc_reg  <= 1'b0;
			case (rx_st_reg)
				ST_HUNT: if (I_DEM_VALID) begin
					rx_sh_reg     <= shifted;
					// reload the preamble window on every preamble byte
					if (I_DEM_DATA == PREAMBLE_BYTE) rx_pre_reg <= 3'h4;
					else if (pre_seen) rx_pre_reg <= rx_pre_reg - 3'h1;
					rx_cnt_reg    <= 8'h00;
					rx_first_reg  <= 1'b1;
					rx_crc_reg    <= CRC_INIT;
					rx_crc_lo_reg <= 1'b0;
					rx_stat2_reg  <= 1'b0;
				end
				ST_DATA: if (I_DEM_VALID) begin
					rx_first_reg <= 1'b0;
					rx_crc_reg   <= crc_byte(rx_crc_reg, I_DEM_DATA);
					rx_pre_reg   <= 3'h0;
					rx_sh_reg    <= 32'h0000_0000;
					if (rx_len_b && len_bad) begin
						rx_disc_reg <= 1'b1;
					end else begin
						rx_data_reg  <= I_DEM_DATA;
						rx_valid_reg <= 1'b1;
						if (rx_len_b) rx_len_reg <= I_DEM_DATA;
						else rx_cnt_reg <= rx_cnt_reg + 8'h01;
					end
				end
				ST_CRC: if (I_DEM_VALID) begin
					rx_crc_reg    <= crc_byte(rx_crc_reg, I_DEM_DATA);
					rx_crc_lo_reg <= 1'b1;
				end
				ST_STAT: if (I_CFG.append_status) begin
					rx_valid_reg <= 1'b1;
					rx_stat2_reg <= 1'b1;
					if (!rx_stat2_reg) rx_data_reg <= I_SIGNAL_STRENGTH_VALUE;
					else rx_data_reg <= {crc_good, 7'h00};
				end
				default: begin
					rx_pre_reg <= 3'h0;
					rx_sh_reg  <= 32'h0000_0000;
				end
			endcase
		end
	end
endmodule

/* rph_pkg.sv */
// Purpose: shared constants and types for the radio packet handler
// Assumes: byte-wide modem interface, one clock
// Notes:   field codes follow the packet automation and modem configuration
package rph_pkg;
	localparam logic [1:0] LEN_FIXED    = 2'h0;
	localparam logic [1:0] LEN_VARIABLE = 2'h1;
	localparam logic [1:0] LEN_INFINITE = 2'h2;
	localparam logic [2:0] SYNC_DBL_A   = 3'h3;
	localparam logic [2:0] SYNC_DBL_B   = 3'h7;
	localparam logic [7:0] PREAMBLE_BYTE = 8'haa;
	localparam logic [15:0] CRC_INIT    = 16'hffff;
	localparam logic [15:0] CRC_POLY    = 16'h8005;
	localparam int          CRC_OK_BIT  = 7;

	// configuration bits set by the host
	typedef struct packed {
		logic [7:0] packet_length_limit;
		logic [1:0] length_mode;
		logic       crc_en;
		logic       append_status;
		logic [2:0] sync_mode;
		logic [7:0] num_preamble;
		logic [7:0] syncword_high_byte;
		logic [7:0] syncword_low_byte;
	} rph_cfg_s;

	typedef enum logic [3:0] {
		ST_IDLE  = 4'h0,
		ST_PRE   = 4'h1,
		ST_SYNC  = 4'h3,
		ST_DATA  = 4'h2,
		ST_CRC   = 4'h6,
		ST_DONE  = 4'h7,
		ST_UFLOW = 4'h5,
		ST_HUNT  = 4'h4,
		ST_STAT  = 4'hc
	} rph_state_e;
endpackage

/* rph_top_properties.sv */
// Purpose: port-level checks for the radio packet handler
// Assumes: one clock, active-low asynchronous reset
// Notes:   bound into every rph_top instance
`timescale 1ns/1ps
module rph_top_properties
	import rph_pkg::*;
(
	input wire logic                I_CLK,
	input wire logic                I_RST_B,
	input wire rph_pkg::rph_cfg_s   I_CFG,
	input wire logic                I_TX_EN,
	input wire logic                I_RX_EN,
	input wire logic                I_TX_FIFO_FLUSH_CMD,
	input wire logic                I_MOD_READY,
	input wire logic                I_DEM_VALID,
	input wire logic [7:0]          I_DEM_DATA,
	input wire logic                O_TX_FIFO_READY,
	input wire logic                O_MOD_VALID,
	input wire logic [7:0]          O_MOD_DATA,
	input wire logic                O_TX_UNDERFLOW_STATE,
	input wire logic                O_TX_DONE,
	input wire logic                O_RX_DONE,
	input wire logic                O_RX_DISCARD,
	input wire logic                O_SYNC_SEEN
);
	default clocking dcb @(posedge I_CLK);
	endclocking
	default disable iff (!I_RST_B);
	// transmit framing and handshake
	AST_MOD_HOLD:
	assert property (O_MOD_VALID && !I_MOD_READY |=> O_MOD_VALID && $stable(O_MOD_DATA)) else $error("modem byte lost");
	AST_TX_START:
	assert property ($rose(I_TX_EN) && !O_MOD_VALID && !O_TX_UNDERFLOW_STATE && !O_TX_DONE
		|-> ##2 O_MOD_VALID && O_MOD_DATA == PREAMBLE_BYTE) else $error("no preamble after enable");
	AST_TX_DONE_CAUSE:
	assert property (O_TX_DONE |-> $past(O_MOD_VALID) && $past(I_MOD_READY)) else $error("done without last byte");
	AST_TX_DONE_ONE:
	assert property (O_TX_DONE |=> !O_TX_DONE) else $error("done longer than one cycle");
	// underflow is sticky until flushed
	AST_UFLOW_HOLD:
	assert property (O_TX_UNDERFLOW_STATE && !I_TX_FIFO_FLUSH_CMD |=> O_TX_UNDERFLOW_STATE) else $error("underflow left");
	AST_UFLOW_NO_POP:
	assert property (O_TX_UNDERFLOW_STATE |-> !O_TX_FIFO_READY) else $error("fifo popped in underflow");
	// receive side
	AST_SYNC_CAUSE:
	assert property ($rose(O_SYNC_SEEN) && I_RX_EN |-> $past(I_DEM_VALID) && $past(I_DEM_DATA) == I_CFG.syncword_low_byte)
		else $error("sync flagged without sync byte");
	AST_DISCARD_QUIET:
	assert property (O_RX_DISCARD |=> !O_RX_DONE [*3]) else $error("discarded packet completed");
	cover property (O_TX_DONE);
	cover property (O_RX_DONE);
	cover property (O_RX_DISCARD);
	cover property (O_TX_UNDERFLOW_STATE);
endmodule
bind rph_top rph_top_properties u_props (.I_CLK(I_CLK), .I_RST_B(I_RST_B), .I_CFG(I_CFG), .I_TX_EN(I_TX_EN),
	.I_RX_EN(I_RX_EN), .I_TX_FIFO_FLUSH_CMD(I_TX_FIFO_FLUSH_CMD), .I_MOD_READY(I_MOD_READY),
	.I_DEM_VALID(I_DEM_VALID), .I_DEM_DATA(I_DEM_DATA), .O_TX_FIFO_READY(O_TX_FIFO_READY),
	.O_MOD_VALID(O_MOD_VALID), .O_MOD_DATA(O_MOD_DATA), .O_TX_UNDERFLOW_STATE(O_TX_UNDERFLOW_STATE),
	.O_TX_DONE(O_TX_DONE), .O_RX_DONE(O_RX_DONE), .O_RX_DISCARD(O_RX_DISCARD), .O_SYNC_SEEN(O_SYNC_SEEN));

/* rph_host_model.sv */
// Purpose: host side model, tx fifo source and modem sink
// Assumes: bench pushes bytes into q between clock edges
// Notes:   cap holds every byte the modem accepted
`timescale 1ns/1ps
module rph_host_model (
	input  wire logic       i_clk,
	input  wire logic       i_slow,
	input  wire logic       i_flush,
	input  wire logic       i_fifo_ready,
	input  wire logic       i_mod_valid,
	input  wire logic [7:0] i_mod_data,
	output logic            o_fifo_valid,
	output logic [7:0]      o_fifo_data,
	output logic            o_mod_ready
);
	logic [7:0] q[$];
	logic [7:0] cap[$];
	initial begin
		o_fifo_valid = 1'b0;
		o_fifo_data = 8'h00;
		o_mod_ready = 1'b1;
	end
	// pop, flush, capture; stale head shown inverted
	always @(posedge i_clk) begin
		if (i_flush)
			q.delete();
		else if (o_fifo_valid && i_fifo_ready)
			void'(q.pop_front());
		if (i_mod_valid && o_mod_ready)
			cap.push_back(i_mod_data);
		o_mod_ready <= i_slow ? ~o_mod_ready : 1'b1;
		o_fifo_valid <= q.size() > 0;
		o_fifo_data <= (q.size() > 0) ? q[0] : ~o_fifo_data;
	end
endmodule

/* rph_tb_top.sv */
// Purpose: self-checking bench, tx rows looped back into rx
// Assumes: host changes config only while idle, except the infinite to fixed switch made mid-packet
// Notes:   underflow, discard and crc error tested by hand
`timescale 1ns/1ps
module rph_tb_top;
	import rph_pkg::*;
	typedef struct packed {
		logic [1:0] mode; logic crc; logic [2:0] sm; logic [7:0] npre, len; logic slow, late; logic [7:0] nbody;
	} rph_row_s;
	localparam logic [7:0] SH = 8'hd3;
	localparam logic [7:0] SL = 8'h91;
	logic       clk, rst_b, tx_en, rx_en, flush, dem_v, slow, fv, fr_rdy, mr, mv, rxv, uf, txd, rxdn, disc, sync;
	logic [7:0] dem_d, ss, fd, md, rxd;
	logic [15:0] c;
	rph_cfg_s   cfg;
	logic [7:0] rxq[$], pl[$], eb[$], fr[$];
	int         miscompares, total_checks, disc_cnt, d0;
	rph_row_s   rows [4] = '{'{LEN_FIXED, 1'b0, 3'h1, 8'h01, 8'h01, 1'b0, 1'b0, 8'h03},
		'{LEN_VARIABLE, 1'b1, 3'h3, 8'h04, 8'h03, 1'b1, 1'b0, 8'h0a},
		'{LEN_FIXED, 1'b1, 3'h7, 8'h02, 8'h02, 1'b0, 1'b1, 8'h08},
		'{LEN_VARIABLE, 1'b0, 3'h2, 8'h08, 8'h01, 1'b1, 1'b0, 8'h04}};
	rph_top uut (.I_CLK(clk), .I_RST_B(rst_b), .I_CFG(cfg), .I_TX_EN(tx_en), .I_RX_EN(rx_en),
		.I_TX_FIFO_FLUSH_CMD(flush), .I_TX_FIFO_VALID(fv), .I_TX_FIFO_DATA(fd), .O_TX_FIFO_READY(fr_rdy),
		.I_MOD_READY(mr), .O_MOD_VALID(mv), .O_MOD_DATA(md), .I_DEM_VALID(dem_v), .I_DEM_DATA(dem_d),
		.I_SIGNAL_STRENGTH_VALUE(ss), .O_RX_FIFO_VALID(rxv), .O_RX_FIFO_DATA(rxd), .O_TX_UNDERFLOW_STATE(uf),
		.O_TX_DONE(txd), .O_RX_DONE(rxdn), .O_RX_DISCARD(disc), .O_SYNC_SEEN(sync));
	rph_host_model p (.i_clk(clk), .i_slow(slow), .i_flush(flush), .i_fifo_ready(fr_rdy), .i_mod_valid(mv),
		.i_mod_data(md), .o_fifo_valid(fv), .o_fifo_data(fd), .o_mod_ready(mr));
	// clock and receive fifo monitor
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(negedge clk) begin
		if (rxv === 1'b1) rxq.push_back(rxd);
		if (disc === 1'b1) disc_cnt++;
	end
	function automatic logic [15:0] crc16(input logic [7:0] b[$]);
		logic [15:0] r = CRC_INIT;
		foreach (b[i]) for (int k = 7; k >= 0; k--) r = {r[14:0], 1'b0} ^ ((r[15] ^ b[i][k]) ? CRC_POLY : 16'h0000);
		return r;
	endfunction
	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		total_checks++;
		if (seen !== want) begin
			miscompares++;
			$display("CHECK FAILED %0t seen %h want %h", $time, seen, want);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// bounded wait: 0 tx done, 1 rx done, 2 underflow
	task automatic wait_ev(input int sel);
		for (int k = 0; k < 2000; k++) begin
			@(negedge clk);
			if ((sel == 0 && txd === 1'b1) || (sel == 1 && rxdn === 1'b1) || (sel == 2 && uf === 1'b1)) return;
		end
		miscompares++;
		end_sim();
	endtask
	task automatic cfgset(input logic [1:0] m, input logic cr, input logic [2:0] sm, input logic [7:0] np, lim);
		@(posedge clk);
		cfg <= '{lim, m, cr, 1'b1, sm, np, SH, SL};
	endtask
	task automatic feed(input logic [7:0] b[$]);
		foreach (b[i]) begin
			@(posedge clk);
			dem_v <= 1'b1;
			dem_d <= b[i];
		end
		@(posedge clk);
		dem_v <= 1'b0;
		dem_d <= ~dem_d;
	endtask
	task automatic rx_cmp(input logic [7:0] b[$]);
		rxq = {};
		@(posedge clk);
		rx_en <= 1'b1;
		feed(b);
		wait_ev(1);
		@(posedge clk);
		rx_en <= 1'b0;
		check(8'(rxq.size()), 8'(fr.size()));
		foreach (fr[i]) check(rxq[i], fr[i]);
	endtask
	task automatic run_row(input rph_row_s w);
		int n = 0;
		cfgset(w.mode, w.crc, w.sm, w.npre, w.len);
		slow <= w.slow;
		pl = {};
		if (w.mode == LEN_VARIABLE) pl.push_back(w.len);
		for (int i = 0; i < w.len; i++) pl.push_back(8'h30 + i[7:0]);
		c = crc16(pl);
		eb = (w.sm == SYNC_DBL_A || w.sm == SYNC_DBL_B) ? {SH, SL, SH, SL} : {SH, SL};
		eb = w.crc ? {eb, pl, c[15:8], c[7:0]} : {eb, pl};
		@(negedge clk);
		p.cap = {};
		if (!w.late) p.q = pl;
		@(posedge clk);
		tx_en <= 1'b1;
		if (w.late) begin
			repeat (12) @(negedge clk);
			p.q = pl;
		end
		wait_ev(0);
		@(posedge clk);
		tx_en <= 1'b0;
		slow <= 1'b0;
		repeat (3) @(negedge clk);
		while (n < p.cap.size() && p.cap[n] == PREAMBLE_BYTE) n++;
		check(8'(n >= w.npre), 8'h01);
		check(8'(p.cap.size() - n), w.nbody);
		foreach (eb[i]) check(p.cap[n + i], eb[i]);
		fr = {pl, ss, 8'h80};
		rx_cmp(p.cap);
	endtask
	// reset, table rows, then the awkward cases
	initial begin
		{rst_b, tx_en, rx_en, flush, dem_v, slow, dem_d, miscompares, total_checks, disc_cnt} = '0;
		ss = 8'h5c;
		cfg = '0;
		repeat (2) @(posedge clk);
		check({4'h0, mv, rxv, uf, txd}, 8'h00);
		rst_b <= 1'b1;
		foreach (rows[r]) run_row(rows[r]);
		cfgset(LEN_FIXED, 1'b0, 3'h1, 8'h01, 8'h03);
		@(negedge clk);
		p.q = {8'h41};
		@(posedge clk);
		tx_en <= 1'b1;
		wait_ev(2);
		@(posedge clk);
		tx_en <= 1'b0;
		@(negedge clk);
		p.q = {8'h42};
		repeat (6) @(negedge clk);
		check(8'(uf), 8'h01);
		@(posedge clk);
		flush <= 1'b1;
		@(posedge clk);
		flush <= 1'b0;
		repeat (3) @(negedge clk);
		check(8'(uf), 8'h00);
		cfgset(LEN_VARIABLE, 1'b0, 3'h1, 8'h01, 8'h02);
		for (int j = 0; j < 2; j++) begin
			d0 = disc_cnt;
			@(posedge clk);
			rx_en <= 1'b1;
			feed({PREAMBLE_BYTE, PREAMBLE_BYTE, SH, SL, j ? 8'h03 : 8'h00, 8'h55, 8'h66});
			@(posedge clk);
			rx_en <= 1'b0;
			check(8'(disc_cnt - d0), 8'h01);
		end
		cfgset(LEN_FIXED, 1'b1, 3'h1, 8'h01, 8'h01);
		c = crc16({8'h5a});
		fr = {8'h5a, ss, 8'h00};
		rx_cmp({PREAMBLE_BYTE, PREAMBLE_BYTE, SH, SL, 8'h5a, c[15:8], ~c[7:0]});
		// infinite start past the limit, then fixed length ends the packet
		cfgset(LEN_INFINITE, 1'b0, 3'h1, 8'h01, 8'h03);
		@(negedge clk);
		p.cap = {};
		p.q = {8'h61, 8'h62, 8'h63, 8'h64, 8'h65, 8'h66, 8'h67, 8'h68, 8'h69, 8'h6a};
		@(posedge clk);
		tx_en <= 1'b1;
		repeat (9) @(negedge clk);
		cfgset(LEN_FIXED, 1'b0, 3'h1, 8'h01, 8'h0a);
		wait_ev(0);
		@(posedge clk);
		tx_en <= 1'b0;
		repeat (3) @(negedge clk);
		d0 = 0;
		while (d0 < p.cap.size() && p.cap[d0] == PREAMBLE_BYTE) d0++;
		check(8'(p.cap.size() - d0), 8'h0c);
		check(p.cap[p.cap.size() - 1], 8'h6a);
		end_sim();
	end
endmodule
